/* File: hdl/spd_core.sv */
`timescale 1ns/1ps
`default_nettype none
module spd_core (
    // clock and reset
    input  wire logic clk,
    input  wire logic sys_rst,
    // crystal oscillator tap and reference
    input  wire logic xtal_in,
    output logic      ref_out,
    // comparator
    input  wire logic cmp_ref_in,
    input  wire logic cmp_fb_in,
    output logic      lead_n_out,
    output logic      lag_out,
    // two-modulus prescaler
    input  wire logic pre_clk_in,
    input  wire logic mod_ctrl_in,
    output logic      pre_out
);
    // ------------------------------------------------------------
    // edge detection
    // ------------------------------------------------------------
    logic xtal_d_r, ref_d_r, fb_d_r, pclk_d_r;
    wire  xtal_rise = xtal_in & ~xtal_d_r;
    wire  ref_fall  = ref_d_r & ~cmp_ref_in;
    wire  fb_fall   = fb_d_r & ~cmp_fb_in;
    wire  pclk_rise = pre_clk_in & ~pclk_d_r;

    // previous samples of the inputs
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            xtal_d_r <= 1'b0;
            ref_d_r  <= 1'b0;
            fb_d_r   <= 1'b0;
            pclk_d_r <= 1'b0;
        end else begin
            xtal_d_r <= xtal_in;
            ref_d_r  <= cmp_ref_in;
            fb_d_r   <= cmp_fb_in;
            pclk_d_r <= pre_clk_in;
        end
    end

    // ------------------------------------------------------------
    // divide by four reference
    // ------------------------------------------------------------
    logic [1:0] ref_cnt_r;
    wire  [1:0] ref_cnt_nxt = xtal_rise ? ref_cnt_r + 2'h1 : ref_cnt_r;

    // counter msb is a square wave at a quarter of the crystal rate
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            ref_cnt_r <= spd_pkg::REF_CNT_RST;
            ref_out   <= 1'b0;
        end else begin
            ref_cnt_r <= ref_cnt_nxt;
            ref_out   <= ref_cnt_nxt[1];
        end
    end

    // ------------------------------------------------------------
    // phase/frequency comparator
    // ------------------------------------------------------------
    spd_pkg::spd_state_t st_r, st_nxt;

    // tri-state detector: first edge opens a pulse, the other closes it
    always_comb begin
        st_nxt = st_r;
        unique case (st_r)
            spd_pkg::SPD_IDLE: begin
                if (ref_fall && !fb_fall)
                    st_nxt = spd_pkg::SPD_LEAD;
                else if (fb_fall && !ref_fall)
                    st_nxt = spd_pkg::SPD_LAG;
            end
            spd_pkg::SPD_LEAD: begin
                if (fb_fall)
                    st_nxt = spd_pkg::SPD_IDLE;
            end
            spd_pkg::SPD_LAG: begin
                if (ref_fall)
                    st_nxt = spd_pkg::SPD_IDLE;
            end
            default: st_nxt = spd_pkg::SPD_IDLE;
        endcase
    end

    // repeated edges of one input keep the state, giving frequency pull-in
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            st_r       <= spd_pkg::SPD_IDLE;
            lead_n_out <= 1'b1;
            lag_out    <= 1'b0;
        end else begin
            st_r       <= st_nxt;
            lead_n_out <= (st_nxt != spd_pkg::SPD_LEAD);
            lag_out    <= (st_nxt == spd_pkg::SPD_LAG);
        end
    end

    // ------------------------------------------------------------
    // two-modulus prescaler
    // ------------------------------------------------------------
    logic [3:0] pre_cnt_r;
    wire  [3:0] pre_top     = mod_ctrl_in ? spd_pkg::PRE_TOP_16 : spd_pkg::PRE_TOP_15;
    wire        pre_wrap    = (pre_cnt_r >= pre_top);
    wire  [3:0] pre_cnt_nxt = !pclk_rise ? pre_cnt_r :
                              pre_wrap ? spd_pkg::PRE_CNT_RST : pre_cnt_r + 4'h1;

    // output high for the first eight counts of each cycle, falls once per cycle
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            pre_cnt_r <= spd_pkg::PRE_CNT_RST;
            pre_out   <= 1'b1;
        end else begin
            pre_cnt_r <= pre_cnt_nxt;
            pre_out   <= (pre_cnt_nxt < spd_pkg::PRE_HALF);
        end
    end

    // ------------------------------------------------------------
    // pulse bookkeeping for the checks
    // ------------------------------------------------------------
    logic [7:0] sep_cnt_r;    // edges since the opening edge
    logic [7:0] width_cnt_r;  // edges with a pulse standing
    wire        pulse_on      = !lead_n_out || lag_out;
    wire        pair_close    = (st_r == spd_pkg::SPD_LEAD && fb_fall)
                              || (st_r == spd_pkg::SPD_LAG && ref_fall);
    wire        sep_sat       = (sep_cnt_r == 8'hFF);
    wire        width_sat     = (width_cnt_r == 8'hFF);
    wire  [7:0] sep_cnt_nxt   = (st_r == spd_pkg::SPD_IDLE) ? spd_pkg::CHK_CNT_RST
                              : sep_cnt_r + {7'h00, !sep_sat};
    wire  [7:0] width_cnt_nxt = !pulse_on ? spd_pkg::CHK_CNT_RST
                              : width_cnt_r + {7'h00, !width_sat};

    // both saturate, so a long pull-in cannot wrap them apart
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            sep_cnt_r   <= spd_pkg::CHK_CNT_RST;
            width_cnt_r <= spd_pkg::CHK_CNT_RST;
        end else begin
            sep_cnt_r   <= sep_cnt_nxt;
            width_cnt_r <= width_cnt_nxt;
        end
    end

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    a_ref_lead_low: assert property (@(posedge clk) disable iff (sys_rst)
        (st_r == spd_pkg::SPD_IDLE && ref_fall && !fb_fall) |=> (!lead_n_out && !lag_out))
        else $error("reference first did not start lead pulse");
    a_fb_lag_high: assert property (@(posedge clk) disable iff (sys_rst)
        (st_r == spd_pkg::SPD_IDLE && fb_fall && !ref_fall) |=> (lag_out && lead_n_out))
        else $error("feedback first did not start lag pulse");
    a_pulse_ends: assert property (@(posedge clk) disable iff (sys_rst)
        (st_r == spd_pkg::SPD_LEAD && fb_fall) |=> lead_n_out)
        else $error("lead pulse did not end at feedback edge");
    a_idle_outputs: assert property (@(posedge clk) disable iff (sys_rst)
        (st_r == spd_pkg::SPD_LAG && ref_fall) |=> (lead_n_out && !lag_out))
        else $error("comparator not idle after both edges");
    a_never_both: assert property (@(posedge clk) disable iff (sys_rst)
        !(!lead_n_out && lag_out))
        else $error("lead and lag active together");
    a_rise_ignored: assert property (@(posedge clk) disable iff (sys_rst)
        (!ref_fall && !fb_fall && st_r == spd_pkg::SPD_IDLE) |=> (lead_n_out && !lag_out))
        else $error("comparator reacted without a falling edge");
    a_lock_narrow: assert property (@(posedge clk) disable iff (sys_rst)
        (st_r == spd_pkg::SPD_IDLE && ref_fall && fb_fall) |=> (lead_n_out && !lag_out)[*2]
        ##1 ((lead_n_out && !lag_out) || $past(ref_fall || fb_fall)))
        else $error("coincident edges gave a pulse");
    a_ref_toggle: assert property (@(posedge clk) disable iff (sys_rst)
        (xtal_rise && ref_cnt_r == 2'h1) |=> (ref_out == 1'b1))
        else $error("reference divider wrong");
    a_pre_wrap: assert property (@(posedge clk) disable iff (sys_rst)
        (pclk_rise && !mod_ctrl_in && pre_cnt_r == spd_pkg::PRE_TOP_15) |=> (pre_cnt_r == 4'h0))
        else $error("divide by fifteen did not wrap");
    a_pre_sixteen: assert property (@(posedge clk) disable iff (sys_rst)
        (pclk_rise && mod_ctrl_in && pre_cnt_r == spd_pkg::PRE_TOP_15) |=> (pre_cnt_r == spd_pkg::PRE_TOP_16))
        else $error("divide by sixteen wrapped early");

    // pulse stretching under repeated edges and pulse width
    a_lead_holds: assert property (@(posedge clk) disable iff (sys_rst)
        (st_r == spd_pkg::SPD_LEAD && !fb_fall) |=> (!lead_n_out && !lag_out))
        else $error("lead pulse ended without feedback edge");
    a_lag_holds: assert property (@(posedge clk) disable iff (sys_rst)
        (st_r == spd_pkg::SPD_LAG && !ref_fall) |=> (lag_out && lead_n_out))
        else $error("lag pulse ended without reference edge");
    a_width_match: assert property (@(posedge clk) disable iff (sys_rst)
        pair_close |-> (pulse_on && width_cnt_r == sep_cnt_r))
        else $error("pulse width differs from edge separation");

    // reference divider edges
    a_ref_fall_edge: assert property (@(posedge clk) disable iff (sys_rst)
        (xtal_rise && ref_cnt_r == 2'h3) |=> !ref_out)
        else $error("reference did not fall on fourth crystal rise");
    a_ref_hold: assert property (@(posedge clk) disable iff (sys_rst)
        !xtal_rise |=> $stable(ref_out))
        else $error("reference moved without a crystal rise");

    // prescaler output shape
    a_pre_half: assert property (@(posedge clk) disable iff (sys_rst)
        (pclk_rise && pre_cnt_r == 4'h7) |=> !pre_out)
        else $error("prescaler output did not fall at half count");
    a_pre_wrap16: assert property (@(posedge clk) disable iff (sys_rst)
        (pclk_rise && mod_ctrl_in && pre_cnt_r == spd_pkg::PRE_TOP_16)
        |=> (pre_cnt_r == spd_pkg::PRE_CNT_RST && pre_out))
        else $error("divide by sixteen did not wrap high");
    a_pre_rise15: assert property (@(posedge clk) disable iff (sys_rst)
        (pclk_rise && !mod_ctrl_in && pre_cnt_r == spd_pkg::PRE_TOP_15) |=> pre_out)
        else $error("divide by fifteen output did not rise at wrap");
    a_pre_idle: assert property (@(posedge clk) disable iff (sys_rst)
        !pclk_rise |=> $stable({pre_cnt_r, pre_out}))
        else $error("prescaler moved without a clock rise");

    // coverage of the main scenarios

    c_lead: cover property (@(posedge clk) disable iff (sys_rst) !lead_n_out);
    c_lag: cover property (@(posedge clk) disable iff (sys_rst) lag_out);
    c_lock: cover property (@(posedge clk) disable iff (sys_rst) ref_fall && fb_fall);
    c_pre_fall: cover property (@(posedge clk) disable iff (sys_rst) $fell(pre_out) && !mod_ctrl_in);
    c_pullin: cover property (@(posedge clk) disable iff (sys_rst) st_r == spd_pkg::SPD_LEAD && ref_fall);
endmodule : spd_core
`default_nettype wire

/* File: hdl/spd_pkg.sv */
`default_nettype none
package spd_pkg;
    // ------------------------------------------------------------
    // timing
    // ------------------------------------------------------------
    localparam int CLK_PERIOD_NS     = 10;
    localparam int ZERO_PULSE_MAX_NS = 30;
    localparam int ZERO_PULSE_CYC    = (ZERO_PULSE_MAX_NS / CLK_PERIOD_NS) < 1 ? 1
                                       : (ZERO_PULSE_MAX_NS / CLK_PERIOD_NS);
    // ------------------------------------------------------------
    // dividers
    // ------------------------------------------------------------
    localparam int          REF_DIV      = 4;
    localparam logic [1:0]  REF_CNT_RST  = 2'h0;
    localparam logic [3:0]  PRE_TOP_16   = 4'hF;
    localparam logic [3:0]  PRE_TOP_15   = 4'hE;
    localparam logic [3:0]  PRE_HALF     = 4'h8;
    localparam logic [3:0]  PRE_CNT_RST  = 4'h0;
    // pulse bookkeeping counters used by the checks
    localparam logic [7:0]  CHK_CNT_RST  = 8'h00;

    // comparator states
    typedef enum logic [1:0] {SPD_IDLE, SPD_LEAD, SPD_LAG} spd_state_t;
endpackage : spd_pkg
`default_nettype wire

/* File: testbench/spd_ctr_model.sv */
`timescale 1ns/1ps
`default_nettype none
module spd_ctr_model (
    // clock and reset
    input  wire logic clk,
    input  wire logic sys_rst,
    // prescaler side
    input  wire logic pre_out,
    input  wire logic fixed_div,
    output logic      mod_ctrl
);
    logic prev_r;
    logic alt_r;
    // steps on each falling edge of the divided output
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            prev_r <= 1'b1;
            alt_r  <= 1'b0;
        end else begin
            prev_r <= pre_out;
            if (prev_r && !pre_out) begin
                alt_r <= ~alt_r;
            end
        end
    end
    // fixed divide ties the control high
    assign mod_ctrl = fixed_div | alt_r;
endmodule : spd_ctr_model
`default_nettype wire

/* File: testbench/tb_spd_core.sv */
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin miscompares++; $display("[ERR] %0t mismatch", $time); end end
module tb_spd_core;
    logic clk = 1'b0, sys_rst = 1'b1, xtal_in = 1'b0, cmp_ref_in = 1'b1, cmp_fb_in = 1'b1;
    logic pre_clk_in = 1'b0, fixed_div = 1'b1, run_pre = 1'b0;
    logic ref_out, lead_n_out, lag_out, pre_out, mod_ctrl;
    int   miscompares = 0, check_count = 0, cyc = 0, rises = 0;
    time  t0;
    // ------------------------------------------------------------
    // clock, watchdog and free-running inputs
    // ------------------------------------------------------------
    initial begin
        forever #5 clk = ~clk;
    end
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 4000) begin
            miscompares++;
            final_report();
        end
    end
    // square waves below half the clock rate
    always begin
        @(posedge clk);
        #1;
        if (cyc % 2 == 0) xtal_in = ~xtal_in;
        if (run_pre && cyc % 2 == 1) pre_clk_in = ~pre_clk_in;
    end
    always @(posedge pre_clk_in) rises++;
    spd_core dut (.clk(clk), .sys_rst(sys_rst), .xtal_in(xtal_in), .ref_out(ref_out),
                  .cmp_ref_in(cmp_ref_in), .cmp_fb_in(cmp_fb_in), .lead_n_out(lead_n_out),
                  .lag_out(lag_out), .pre_clk_in(pre_clk_in), .mod_ctrl_in(mod_ctrl), .pre_out(pre_out));
    spd_ctr_model ctr (.clk(clk), .sys_rst(sys_rst), .pre_out(pre_out), .fixed_div(fixed_div),
                       .mod_ctrl(mod_ctrl));
    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    // one comparison: falling edges at given cycles, pulse widths counted
    task automatic cmp_pair(input int ref_at, input int fb_at, input int exp_lead, input int exp_lag);
        int n_lead;
        int n_lag;
        n_lead = 0;
        n_lag  = 0;
        for (int i = 0; i < 16; i++) begin
            @(posedge clk);
            #1;
            if (i == ref_at) cmp_ref_in = 1'b0;
            if (i == fb_at) cmp_fb_in = 1'b0;
            if (i == 11) cmp_ref_in = 1'b1;
            if (i == 12) cmp_fb_in = 1'b1;
            n_lead += (lead_n_out === 1'b0);
            n_lag += (lag_out === 1'b1);
        end
        `CHK(n_lead, exp_lead)
        `CHK(n_lag, exp_lag)
        `CHK({lead_n_out, lag_out}, 2'h2)
        $display("cmp test %0d/%0d done", ref_at, fb_at);
    endtask : cmp_pair
    // second reference edge before the feedback edge stretches one lead pulse
    task automatic cmp_pullin;
        int n_lead;
        int n_lag;
        n_lead = 0;
        n_lag  = 0;
        for (int i = 0; i < 16; i++) begin
            @(posedge clk);
            #1;
            if (i == 1 || i == 5) cmp_ref_in = 1'b0;
            if (i == 3 || i == 7) cmp_ref_in = 1'b1;
            if (i == 9) cmp_fb_in = 1'b0;
            if (i == 12) cmp_fb_in = 1'b1;
            n_lead += (lead_n_out === 1'b0);
            n_lag += (lag_out === 1'b1);
        end
        `CHK(n_lead, 8)
        `CHK(n_lag, 0)
        `CHK({lead_n_out, lag_out}, 2'h2)
        $display("pull-in test done");
    endtask : cmp_pullin
    // reference period is four crystal periods of 40 ns
    task automatic ref_div;
        @(posedge ref_out);
        t0 = $time;
        @(posedge ref_out);
        `CHK($time - t0, spd_pkg::REF_DIV * 40)
        $display("ref test done");
    endtask : ref_div
    // two prescaler periods counted in input rises
    task automatic pre_div(input logic fix, input int exp);
        @(posedge clk);
        #1;
        fixed_div = fix;
        @(negedge pre_out);
        @(negedge pre_out);
        rises = 0;
        @(negedge pre_out);
        @(negedge pre_out);
        `CHK(rises, exp)
        $display("prescaler test %0d done", exp);
    endtask : pre_div
    task automatic final_report;
        $display("checks %0d mismatches %0d", check_count, miscompares);
        if (miscompares == 0 && check_count > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask : final_report
    // main sequence
    initial begin
        repeat (2) @(posedge clk);
        #1;
        sys_rst = 1'b0;
        run_pre = 1'b1;
        ref_div();
        cmp_pair(2, 6, 4, 0);
        cmp_pair(6, 3, 0, 3);
        cmp_pair(4, 4, 0, 0);
        cmp_pullin();
        pre_div(1'b1, 32);
        pre_div(1'b0, 31);
        final_report();
    end
endmodule : tb_spd_core
`default_nettype wire
